/* hw/ctu_edge_det.sv */
`timescale 1ns/100ps
module ctu_edge_det
  import ctu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [NSRC-1:0] src,
  input wire logic [SEL_W-1:0] sel,
  input wire logic edge_mode,
  input wire logic polarity,
  output logic hit
);
  logic [NSRC-1:0] sync1_r, sync1_nxt;
  logic [NSRC-1:0] sync2_r, sync2_nxt;
  logic prev_r, prev_nxt;
  logic lvl;

  always_comb begin
    sync1_nxt = src;
    sync2_nxt = sync1_r;
    lvl = sync2_r[sel] ~^ polarity;
    prev_nxt = lvl;
    // edge or level response
    hit = edge_mode ? (lvl & ~prev_r) : lvl;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= 1'b1;
    end else if (clk_en) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end
endmodule : ctu_edge_det

/* hw/ctu_top.sv */
// Our own choice: the strobed register port.
`timescale 1ns/100ps
// Behaviour
// - edge-1 sample mode bit 31 picks edge (1) or level (0) sensitivity.
// - edge-1 polarity bit 30 picks rising (1) or falling (0) response.
// - edge-1 source field bits 29-26 picks one of sixteen sources by code.
// - edge-2 status bit 25 is set by edge 2 and is also writable by software.
// - edge-1 status bit 24 is set by edge 1 and is also writable by software.
// - clear, set and invert aliases at base plus 4, 8 and C act on bits written one.
// - every control bit resets to zero.
// - bits 17-16 and 14 ignore writes and read zero.
// - discharge bit grounds the current source output while set.
// - with edge order enabled, edge 2 registers only after edge 1.
// - with edge gate clear, no edge reaches the status bits.
// - trigger output follows the trigger enable bit while the on bit (15) is set, and is low otherwise.
module ctu_top
  import ctu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic idle_req,
  input wire logic timer_event,
  input wire logic compare_event,
  input wire logic [7:0] edge_pin,
  input wire logic [2:0] capture_event,
  input wire logic [2:0] comparator_out,
  input wire logic periph_tick,
  output logic edge1_out,
  output logic edge2_out,
  output logic trigger_out,
  output logic discharge_out,
  output logic delay_gen_out,
  output logic [5:0] current_trim,
  output logic [1:0] current_range,
  output logic irq
);
  logic [31:0] ctl_r, ctl_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic irq_r, irq_nxt;
  logic [NSRC-1:0] src1, src2;
  logic hit1, hit2, run, gate, set1, set2;
  logic [31:0] wv;

  // source maps
  assign src1 = {comparator_out[2], comparator_out[1], comparator_out[0], capture_event[2], capture_event[1],
                 capture_event[0], edge_pin[7:2], edge_pin[0], edge_pin[1], compare_event, timer_event};
  assign src2 = {comparator_out[2], comparator_out[1], comparator_out[0], periph_tick, capture_event[2],
                 capture_event[1], capture_event[0], edge_pin[7:3], edge_pin[0], edge_pin[1], compare_event,
                 timer_event};

  ctu_edge_det u_det1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .src(src1),
    .sel(ctl_r[E1_SEL_LSB +: SEL_W]),
    .edge_mode(ctl_r[E1_MODE_BIT]),
    .polarity(ctl_r[E1_POL_BIT]),
    .hit(hit1)
  );

  ctu_edge_det u_det2 (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .src(src2),
    .sel(ctl_r[E2_SEL_LSB +: SEL_W]),
    .edge_mode(ctl_r[E2_MODE_BIT]),
    .polarity(ctl_r[E2_POL_BIT]),
    .hit(hit2)
  );

  // gating and ordering
  always_comb begin
    run = ctl_r[ON_BIT] & ~(ctl_r[IDLE_STOP_BIT] & idle_req);
    gate = run & ctl_r[EDGE_GATE_BIT];
    set1 = gate & hit1;
    set2 = gate & hit2 & (~ctl_r[EDGE_ORDER_BIT] | ctl_r[E1_STAT_BIT]);
  end

  // control register with aliases
  always_comb begin
    wv = ctl_r;
    if (wr_stb) begin
      case (addr)
        CTU_CONTROL_OFS: wv = wdata;
        CTU_CLR_OFS: wv = ctl_r & ~wdata;
        CTU_SET_OFS: wv = ctl_r | wdata;
        CTU_INV_OFS: wv = ctl_r ^ wdata;
        default: wv = ctl_r;
      endcase
    end
    ctl_nxt = wv & CTU_CONTROL_WMASK;
    // hardware set wins over software clear
    ctl_nxt[E1_STAT_BIT] = wv[E1_STAT_BIT] | set1;
    ctl_nxt[E2_STAT_BIT] = wv[E2_STAT_BIT] | set2;
  end

  // interrupt status and read port
  always_comb begin
    ist_nxt = ist_r | {set2, set1};
    imask_nxt = imask_r;
    rdata_nxt = 32'h00000000;
    if (rd_stb) begin
      case (addr)
        CTU_CONTROL_OFS: rdata_nxt = ctl_r;
        CTU_IRQ_STAT_OFS: begin
          rdata_nxt = {30'h00000000, ist_r};
          ist_nxt = {set2, set1};
        end
        CTU_IRQ_MASK_OFS: rdata_nxt = {30'h00000000, imask_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
    if (wr_stb && addr == CTU_IRQ_MASK_OFS) begin
      imask_nxt = wdata[IRQ_W-1:0];
    end
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_r <= CTU_CONTROL_RST;
      rdata_r <= 32'h00000000;
      ist_r <= IRQ_RST;
      imask_r <= IRQ_RST;
      irq_r <= 1'b0;
      edge1_out <= 1'b0;
      edge2_out <= 1'b0;
      trigger_out <= 1'b0;
      discharge_out <= 1'b0;
      delay_gen_out <= 1'b0;
      current_trim <= 6'h00;
      current_range <= 2'h0;
    end else if (clk_en) begin
      ctl_r <= ctl_nxt;
      rdata_r <= rdata_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
      edge1_out <= ctl_nxt[E1_STAT_BIT];
      edge2_out <= ctl_nxt[E2_STAT_BIT];
      trigger_out <= ctl_nxt[TRIG_EN_BIT] & ctl_nxt[ON_BIT];
      discharge_out <= ctl_nxt[DISCHARGE_BIT];
      delay_gen_out <= ctl_nxt[DELAY_GEN_BIT] & (ctl_nxt[E2_SEL_LSB +: SEL_W] == SEL_COMPARATOR2_OUTPUT);
      current_trim <= ctl_nxt[TRIM_LSB +: 6];
      current_range <= ctl_nxt[RANGE_LSB +: 2];
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (reset) (ctl_r & ~CTU_CONTROL_WMASK) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_gate_blocks;
    @(posedge ref_clk) disable iff (reset) (clk_en && !ctl_r[EDGE_GATE_BIT] && !ctl_r[E1_STAT_BIT] && !wr_stb)
      |=> !ctl_r[E1_STAT_BIT];
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("edge passed closed gate");

  property p_order;
    @(posedge ref_clk) disable iff (reset) (clk_en && ctl_r[EDGE_ORDER_BIT] && !ctl_r[E1_STAT_BIT] &&
      !ctl_r[E2_STAT_BIT] && !wr_stb) |=> !ctl_r[E2_STAT_BIT];
  endproperty
  a_order: assert property (p_order) else $error("edge 2 before edge 1");

  property p_sticky;
    @(posedge ref_clk) disable iff (reset) (clk_en && ctl_r[E1_STAT_BIT] && !wr_stb) |=> ctl_r[E1_STAT_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");

  property p_set_alias;
    @(posedge ref_clk) disable iff (reset) (clk_en && wr_stb && addr == CTU_SET_OFS)
      |=> (ctl_r & $past(wdata) & CTU_CONTROL_WMASK) == ($past(wdata) & CTU_CONTROL_WMASK);
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias failed");

  property p_clr_alias;
    @(posedge ref_clk) disable iff (reset) (clk_en && wr_stb && addr == CTU_CLR_OFS && !gate)
      |=> (ctl_r & $past(wdata)) == 32'h00000000;
  endproperty
  a_clr_alias: assert property (p_clr_alias) else $error("clear alias failed");

  property p_trigger;
    @(posedge ref_clk) disable iff (reset) clk_en |=> trigger_out == (ctl_r[TRIG_EN_BIT] & ctl_r[ON_BIT]);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger mismatch");

  property p_discharge;
    @(posedge ref_clk) disable iff (reset) clk_en |=> discharge_out == ctl_r[DISCHARGE_BIT];
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge mismatch");

  property p_reset_zero;
    @(posedge ref_clk) reset |=> ctl_r == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not reset");

  property p_read_ctl;
    @(posedge ref_clk) disable iff (reset) (clk_en && rd_stb && addr == CTU_CONTROL_OFS)
      |=> rdata_r == $past(ctl_r);
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("control read mismatch");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (reset) (clk_en && !rd_stb)
      |=> rdata_r == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_ctl_write;
    @(posedge ref_clk) disable iff (reset) (clk_en && wr_stb && addr == CTU_CONTROL_OFS && !gate)
      |=> ctl_r == ($past(wdata) & CTU_CONTROL_WMASK);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write failed");

  property p_inv_alias;
    @(posedge ref_clk) disable iff (reset) (clk_en && wr_stb && addr == CTU_INV_OFS && !gate)
      |=> ctl_r == (($past(ctl_r) ^ $past(wdata)) & CTU_CONTROL_WMASK);
  endproperty
  a_inv_alias: assert property (p_inv_alias) else $error("invert alias failed");

  property p_edge1_set;
    @(posedge ref_clk) disable iff (reset) (clk_en && gate && hit1)
      |=> ctl_r[E1_STAT_BIT];
  endproperty
  a_edge1_set: assert property (p_edge1_set) else $error("edge 1 not recorded");

  property p_edge2_set;
    @(posedge ref_clk) disable iff (reset) (clk_en && gate && hit2 && (!ctl_r[EDGE_ORDER_BIT] || ctl_r[E1_STAT_BIT]))
      |=> ctl_r[E2_STAT_BIT];
  endproperty
  a_edge2_set: assert property (p_edge2_set) else $error("edge 2 not recorded");

  property p_off_blocks;
    @(posedge ref_clk) disable iff (reset) (clk_en && !ctl_r[ON_BIT] && !ctl_r[E1_STAT_BIT] && !wr_stb)
      |=> !ctl_r[E1_STAT_BIT];
  endproperty
  a_off_blocks: assert property (p_off_blocks) else $error("edge passed while off");

  property p_idle_blocks;
    @(posedge ref_clk) disable iff (reset) (clk_en && ctl_r[IDLE_STOP_BIT] && idle_req && !ctl_r[E1_STAT_BIT] &&
      !wr_stb) |=> !ctl_r[E1_STAT_BIT];
  endproperty
  a_idle_blocks: assert property (p_idle_blocks) else $error("edge passed while idle");

  property p_sticky2;
    @(posedge ref_clk) disable iff (reset) (clk_en && ctl_r[E2_STAT_BIT] && !wr_stb)
      |=> ctl_r[E2_STAT_BIT];
  endproperty
  a_sticky2: assert property (p_sticky2) else $error("edge 2 status lost");

  property p_edge_out;
    @(posedge ref_clk) disable iff (reset) clk_en
      |=> edge1_out == ctl_r[E1_STAT_BIT] && edge2_out == ctl_r[E2_STAT_BIT];
  endproperty
  a_edge_out: assert property (p_edge_out) else $error("edge outputs mismatch");

  property p_delay_gen;
    @(posedge ref_clk) disable iff (reset) clk_en
      |=> delay_gen_out == (ctl_r[DELAY_GEN_BIT] && ctl_r[E2_SEL_LSB +: SEL_W] == SEL_COMPARATOR2_OUTPUT);
  endproperty
  a_delay_gen: assert property (p_delay_gen) else $error("delay generation mismatch");

  property p_trim_range;
    @(posedge ref_clk) disable iff (reset) clk_en
      |=> current_trim == ctl_r[TRIM_LSB +: 6] && current_range == ctl_r[RANGE_LSB +: 2];
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("trim or range mismatch");

  property p_reset_outputs;
    @(posedge ref_clk) reset
      |=> {edge1_out, edge2_out, trigger_out, discharge_out, delay_gen_out, current_trim, current_range} == 13'h0000;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not reset");

  property p_freeze;
    @(posedge ref_clk) disable iff (reset) !clk_en
      |=> ctl_r == $past(ctl_r) && ist_r == $past(ist_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_irq_level;
    @(posedge ref_clk) disable iff (reset) clk_en
      |=> irq_r == |(ist_r & imask_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

  property p_stat_clear_read;
    @(posedge ref_clk) disable iff (reset) (clk_en && rd_stb && addr == CTU_IRQ_STAT_OFS && !set1 && !set2)
      |=> ist_r == IRQ_RST;
  endproperty
  a_stat_clear_read: assert property (p_stat_clear_read) else $error("status not cleared by read");

  c_edge1: cover property (@(posedge ref_clk) disable iff (reset) set1);
  c_level: cover property (@(posedge ref_clk) disable iff (reset) set1 && !ctl_r[E1_MODE_BIT]);
  c_delay_gen: cover property (@(posedge ref_clk) disable iff (reset) delay_gen_out);
  c_edge2_after: cover property (@(posedge ref_clk) disable iff (reset) set1 ##[1:20] set2);
  c_irq: cover property (@(posedge ref_clk) disable iff (reset) irq_r);
endmodule : ctu_top

/* inc/ctu_pkg.sv */
package ctu_pkg;
  localparam logic [15:0] CTU_CONTROL_OFS = 16'hA200;
  localparam logic [15:0] CTU_CLR_OFS = 16'hA204;
  localparam logic [15:0] CTU_SET_OFS = 16'hA208;
  localparam logic [15:0] CTU_INV_OFS = 16'hA20C;
  localparam logic [15:0] CTU_IRQ_STAT_OFS = 16'hA210;
  localparam logic [15:0] CTU_IRQ_MASK_OFS = 16'hA214;
  localparam logic [31:0] CTU_CONTROL_RST = 32'h00000000;
  localparam logic [31:0] CTU_CONTROL_WMASK = 32'hFFFCBFFF;
  localparam int E1_MODE_BIT = 31;
  localparam int E1_POL_BIT = 30;
  localparam int E1_SEL_LSB = 26;
  localparam int E2_STAT_BIT = 25;
  localparam int E1_STAT_BIT = 24;
  localparam int E2_MODE_BIT = 23;
  localparam int E2_POL_BIT = 22;
  localparam int E2_SEL_LSB = 18;
  localparam int ON_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int DELAY_GEN_BIT = 12;
  localparam int EDGE_GATE_BIT = 11;
  localparam int EDGE_ORDER_BIT = 10;
  localparam int DISCHARGE_BIT = 9;
  localparam int TRIG_EN_BIT = 8;
  localparam int TRIM_LSB = 2;
  localparam int RANGE_LSB = 0;
  localparam int SEL_W = 4;
  localparam int NSRC = 16;
  localparam int IRQ_W = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_COMPARATOR2_OUTPUT = 4'hE;
endpackage : ctu_pkg

/* test/ctu_src_model.sv */
`timescale 1ns/100ps
module ctu_src_model
  import ctu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic fire,
  input wire logic [SEL_W-1:0] fire_sel,
  output logic timer_event,
  output logic compare_event,
  output logic [7:0] edge_pin,
  output logic [2:0] capture_event,
  output logic [2:0] comparator_out
);
  logic [NSRC-1:0] src_r;
  logic [NSRC-1:0] src_nxt;
  // one source active while fire is held, all idle low
  always_comb begin
    src_nxt = '0;
    if (fire) begin
      src_nxt[fire_sel] = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    src_r <= reset ? '0 : src_nxt;
  end
  // sources laid out in edge-1 code order
  assign timer_event = src_r[0];
  assign compare_event = src_r[1];
  assign edge_pin = {src_r[9:4], src_r[2], src_r[3]};
  assign capture_event = src_r[12:10];
  assign comparator_out = src_r[15:13];
endmodule : ctu_src_model

/* test/ctu_top_test.sv */
`timescale 1ns/100ps
module ctu_top_test import ctu_pkg::*;;
  logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic idle_req = 1'b0, periph_tick = 1'b0, fire = 1'b0;
  logic [3:0] fire_sel = 4'h0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h00000000, rdata, base;
  logic timer_event, compare_event, edge1_out, edge2_out, trigger_out, discharge_out, delay_gen_out, irq;
  logic [7:0] edge_pin;
  logic [2:0] capture_event, comparator_out;
  logic [5:0] current_trim;
  logic [1:0] current_range;
  int errors = 0, checked = 0;
  ctu_top u_ctu_top (.ref_clk, .reset, .clk_en, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .idle_req,
    .timer_event, .compare_event, .edge_pin, .capture_event, .comparator_out, .periph_tick, .edge1_out,
    .edge2_out, .trigger_out, .discharge_out, .delay_gen_out, .current_trim, .current_range, .irq);
  ctu_src_model u_ctu_src_model (.ref_clk, .reset, .fire, .fire_sel, .timer_event, .compare_event,
    .edge_pin, .capture_event, .comparator_out);
  always #20 ref_clk = ~ref_clk;
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rc
  task automatic pulse(input logic [3:0] s);
    @(posedge ref_clk);
    fire_sel <= s;
    fire <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fire <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : pulse
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rc(CTU_CONTROL_OFS, 32'h00000000);
    wr(CTU_CONTROL_OFS, 32'hFFFFFFFF);
    rc(CTU_CONTROL_OFS, 32'hFFFCBFFF);
    chk({discharge_out, trigger_out, current_trim, current_range}, 32'h000003FF);
    rc(16'hA220, 32'h00000000);
    wr(CTU_CONTROL_OFS, 32'h00000000);
    wr(CTU_SET_OFS, 32'h00008100);
    rc(CTU_CONTROL_OFS, 32'h00008100);
    chk(trigger_out, 1);
    wr(CTU_INV_OFS, 32'h00000300);
    rc(CTU_CONTROL_OFS, 32'h00008200);
    chk({discharge_out, trigger_out}, 2);
    wr(CTU_CLR_OFS, 32'h00008200);
    rc(CTU_CONTROL_OFS, 32'h00000000);
    $display("register test done");
    wr(CTU_IRQ_MASK_OFS, 32'h00000003);
    for (int c = 0; c < 16; c++) begin
      base = 32'hC0F08800 | (32'(c) << E1_SEL_LSB);
      wr(CTU_CONTROL_OFS, base);
      rc(CTU_CONTROL_OFS, base);
      pulse(c[3:0]);
      rc(CTU_CONTROL_OFS, base | 32'h01000000);
      chk({edge1_out, irq}, 3);
      rc(CTU_IRQ_STAT_OFS, 32'h00000001);
      repeat (2) @(posedge ref_clk);
      chk(irq, 0);
    end
    $display("source test done");
    wr(CTU_CONTROL_OFS, 32'h00F08800);
    repeat (6) @(posedge ref_clk);
    rc(CTU_CONTROL_OFS, 32'h01F08800);
    wr(CTU_CONTROL_OFS, 32'hC0F08000);
    wr(CTU_CLR_OFS, 32'h01000000);
    pulse(4'h0);
    rc(CTU_CONTROL_OFS, 32'hC0F08000);
    wr(CTU_CONTROL_OFS, 32'hC4C08C00);
    pulse(4'h0);
    rc(CTU_CONTROL_OFS, 32'hC4C08C00);
    pulse(4'h1);
    rc(CTU_CONTROL_OFS, 32'hC5C08C00);
    pulse(4'h0);
    rc(CTU_CONTROL_OFS, 32'hC7C08C00);
    chk({edge2_out, edge1_out}, 32'h00000003);
    rc(CTU_IRQ_STAT_OFS, 32'h00000003);
    $display("gate and order test done");
    wr(CTU_CLR_OFS, 32'h03000000);
    clk_en <= 1'b0;
    pulse(4'h1);
    clk_en <= 1'b1;
    rc(CTU_CONTROL_OFS, 32'hC4C08C00);
    wr(CTU_CONTROL_OFS, 32'hC4C0AC00);
    idle_req <= 1'b1;
    pulse(4'h1);
    idle_req <= 1'b0;
    rc(CTU_CONTROL_OFS, 32'hC4C0AC00);
    pulse(4'h1);
    rc(CTU_CONTROL_OFS, 32'hC5C0AC00);
    wr(CTU_CONTROL_OFS, 32'h84C08000);
    wr(CTU_SET_OFS, 32'h00000800);
    rc(CTU_CONTROL_OFS, 32'h84C08800);
    pulse(4'h1);
    rc(CTU_CONTROL_OFS, 32'h85C08800);
    wr(CTU_CONTROL_OFS, 32'hC0F08800);
    periph_tick <= 1'b1;
    repeat (6) @(posedge ref_clk);
    periph_tick <= 1'b0;
    rc(CTU_CONTROL_OFS, 32'hC2F08800);
    wr(CTU_CONTROL_OFS, 32'h00381000);
    rc(CTU_CONTROL_OFS, 32'h00381000);
    chk(delay_gen_out, 32'h00000001);
    $display("freeze idle polarity and delay test done");
    summarize();
  end
endmodule : ctu_top_test
